// ---- bench/core_model.sv ----
// core-side partner: random pending requests, trap and level-load pulses
// assumes calls to pulse are made just after a rising edge
module core_model (
    input wire logic clk,
    output logic load, insvc, rv,
    output logic [3:0] prio, svc, req, trap
);
    timeunit 1ns;
    timeprecision 1ns;
    initial {load, insvc, rv, prio, svc, req, trap} = 0;
    always @(posedge clk) begin
        insvc <= $urandom;
        rv <= $urandom;
        svc <= $urandom;
        req <= $urandom;
    end
    task pulse(input [3:0] t, input l, input [3:0] p);
        trap <= t;
        load <= l;
        prio <= p;
        @(posedge clk);
        trap <= 4'h0;
        load <= 1'b0;
    endtask
endmodule

// ---- bench/cpu_prio_properties.sv ----
// concurrent checks on the priority and trap-status block
// assumes binding to the top module; sees its ports only
module cpu_prio_props #(parameter PRIO_W = 3) (
    input wire logic CORE_CLK_I, SRST_I, CYC_I, STB_I, WE_I, ACK_O, CORE_PRIO_LOAD_I, IN_SERVICE_I,
    input wire logic REQ_VALID_I, USER_IRQ_BLOCKED_O, REQ_ACCEPT_O, NESTING_DISABLE_O, IRQ_O,
    input wire logic [3:0] ADR_I,
    input wire logic [31:0] DAT_O,
    input wire logic [PRIO_W:0] CORE_PRIO_I, SERVICE_PRIO_I, REQ_PRIO_I, CPU_LEVEL_O
);
    timeunit 1ns;
    timeprecision 1ns;
    logic rd0_reg, rd8_reg, rst_reg;
    logic [PRIO_W:0] lv_reg;
    default clocking @(posedge CORE_CLK_I); endclocking
    default disable iff (SRST_I);
    always @(posedge CORE_CLK_I) begin
        rd0_reg <= CYC_I && STB_I && !WE_I && ADR_I == 4'h0;
        rd8_reg <= CYC_I && STB_I && !WE_I && ADR_I == 4'h8;
        lv_reg <= CPU_LEVEL_O;
        rst_reg <= SRST_I;
    end
    ack_once_a: assert property (ACK_O |=> !ACK_O) else $error("ack held too long");
    ack_time_a: assert property (CYC_I && STB_I && !ACK_O |=> ACK_O) else $error("ack late");
    block_lvl_a: assert property (USER_IRQ_BLOCKED_O == (CPU_LEVEL_O[PRIO_W] || &CPU_LEVEL_O[PRIO_W-1:0]))
        else $error("blocking wrong");
    req_accept_a: assert property (REQ_ACCEPT_O == (REQ_VALID_I && !USER_IRQ_BLOCKED_O && REQ_PRIO_I > CPU_LEVEL_O
        && !(IN_SERVICE_I && (NESTING_DISABLE_O || REQ_PRIO_I <= SERVICE_PRIO_I)))) else $error("accept wrong");
    msb_noset_a: assert property (!CORE_PRIO_LOAD_I && !CPU_LEVEL_O[PRIO_W] |=> !CPU_LEVEL_O[PRIO_W])
        else $error("msb set by software");
    nest_lock_a: assert property (NESTING_DISABLE_O && !CORE_PRIO_LOAD_I |=> $stable(CPU_LEVEL_O[PRIO_W-1:0]))
        else $error("field moved while locked");
    core_load_a: assert property (CORE_PRIO_LOAD_I |=> CPU_LEVEL_O == $past(CORE_PRIO_I))
        else $error("core load lost");
    unused_zero_a: assert property (ACK_O && rd8_reg |-> DAT_O[14:5] == 10'h000 && !DAT_O[0])
        else $error("unused bits not zero");
    lvl_read_a: assert property (ACK_O && rd0_reg |-> DAT_O[7:5] == lv_reg[PRIO_W-1:0])
        else $error("field read wrong");
    reset_clr_a: assert property (rst_reg |-> CPU_LEVEL_O == 0 && !NESTING_DISABLE_O && !IRQ_O)
        else $error("reset state wrong");
    cover property (REQ_ACCEPT_O);
    cover property (USER_IRQ_BLOCKED_O);
    cover property (IRQ_O);
endmodule
bind cpu_priority_and_trap_status cpu_prio_props #(.PRIO_W(PRIO_W)) prop_u (.*);

// ---- bench/cpu_priority_and_trap_status_bench.sv ----
// self-checking bench for the priority and trap-status block
// assumes the core model drives the core side; reads are checked from a queue
module cpu_priority_and_trap_status_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic CORE_CLK_I = 0, SRST_I = 1, CYC_I = 0, STB_I = 0, WE_I = 0;
    logic [3:0] ADR_I = 4'h0, SEL_I = 4'h0;
    logic [31:0] DAT_I = 32'h0000_0000, DAT_O, m;
    logic ACK_O, CORE_PRIO_LOAD_I, IN_SERVICE_I, REQ_VALID_I, USER_IRQ_BLOCKED_O, REQ_ACCEPT_O, NESTING_DISABLE_O, IRQ_O;
    logic [3:0] CORE_PRIO_I, SERVICE_PRIO_I, REQ_PRIO_I, CPU_LEVEL_O, trap;
    int error_cnt = 0, total_checks = 0;
    logic [31:0] q[$];
    cpu_priority_and_trap_status dut_u (.*, .OSC_TRAP_I(trap[0]), .STACK_TRAP_I(trap[1]), .ADDR_TRAP_I(trap[2]),
        .ARITH_TRAP_I(trap[3]));
    core_model m_u (.clk(CORE_CLK_I), .load(CORE_PRIO_LOAD_I), .insvc(IN_SERVICE_I), .rv(REQ_VALID_I),
        .prio(CORE_PRIO_I), .svc(SERVICE_PRIO_I), .req(REQ_PRIO_I), .trap(trap));
    initial forever #20 CORE_CLK_I = ~CORE_CLK_I;
    task check(input [31:0] s, input [31:0] e);
        total_checks++;
        if (s !== e) begin
            error_cnt++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task end_sim;
        $display("checks=%0d errors=%0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // for a read, d is the expected data
    task wb(input w, input [3:0] a, input [31:0] d);
        CYC_I <= 1;
        STB_I <= 1;
        WE_I <= w;
        ADR_I <= a;
        DAT_I <= d;
        SEL_I <= 4'hF;
        if (!w) q.push_back(d);
        do @(posedge CORE_CLK_I); while (ACK_O !== 1'b1);
        CYC_I <= 0;
        STB_I <= 0;
        @(posedge CORE_CLK_I);
    endtask
    always @(posedge CORE_CLK_I) if (ACK_O === 1'b1 && !WE_I) check(DAT_O, q.pop_front());
    initial begin
        repeat (20000) @(posedge CORE_CLK_I);
        error_cnt++;
        end_sim;
    end
    initial begin
        m = $urandom(32'h0000_6ffb);
        repeat (6) @(posedge CORE_CLK_I);
        SRST_I <= 0;
        @(posedge CORE_CLK_I);
        for (int a = 0; a < 16; a += 2) wb(0, a[3:0], 32'h0000_0000);
        for (int i = 0; i < 8; i++) begin
            m = $urandom;
            m[7:5] = i[2:0];
            wb(1, 4'h0, m);
            wb(0, 4'h0, {24'h00_0000, i[2:0], 5'h00});
            @(negedge CORE_CLK_I);
            check(CPU_LEVEL_O, i);
            check(USER_IRQ_BLOCKED_O, i == 7);
            check(REQ_ACCEPT_O, REQ_VALID_I && i != 7 && REQ_PRIO_I > i && !(IN_SERVICE_I && REQ_PRIO_I <= SERVICE_PRIO_I));
            @(posedge CORE_CLK_I);
        end
        wb(1, 4'h4, 32'h0000_0008);
        wb(0, 4'h4, 32'h0000_0000);
        m_u.pulse(4'h0, 1, 4'hB);
        wb(0, 4'h4, 32'h0000_0008);
        wb(0, 4'h0, 32'h0000_0060);
        wb(1, 4'h4, 32'h0000_0000);
        wb(0, 4'h4, 32'h0000_0000);
        wb(1, 4'h8, 32'h0000_FFE1);
        wb(0, 4'h8, 32'h0000_8000);
        @(negedge CORE_CLK_I);
        check(NESTING_DISABLE_O, 1);
        @(posedge CORE_CLK_I);
        wb(1, 4'h0, 32'h0000_0000);
        wb(0, 4'h0, 32'h0000_0060);
        wb(1, 4'h8, 32'h0000_0000);
        for (int k = 0; k < 4; k++) begin
            m = $urandom;
            wb(1, 4'hC, m);
            wb(0, 4'hC, m & 32'h0000_000F);
            m_u.pulse(4'h1 << k, 0, 4'h0);
            wb(1, 4'h8, 32'h0000_001E);
            wb(0, 4'h8, 32'h0000_0002 << k);
            @(negedge CORE_CLK_I);
            check(IRQ_O, m[k]);
            @(posedge CORE_CLK_I);
            wb(1, 4'h8, 32'h0000_0000);
            wb(0, 4'h8, 32'h0000_0000);
        end
        end_sim;
    end
endmodule

// ---- common/cpu_priority_defines.vh ----
// register offsets, field positions, reset values for the priority and trap-status block
// assumes a 32-bit classic wishbone slave, one register per aligned word
`ifndef CPU_PRIORITY_DEFINES_VH
`define CPU_PRIORITY_DEFINES_VH

`define OFS_ALU_STATUS 4'h0
`define OFS_CORE_CONTROL 4'h4
`define OFS_INT_CONTROL_ONE 4'h8
`define OFS_TRAP_MASK 4'hC

`define ALU_PRIO_HI 7
`define ALU_PRIO_LO 5
`define CORE_PRIO_MSB_BIT 3
`define INTC1_NEST_DIS_BIT 15
`define INTC1_ARITH_BIT 4
`define INTC1_ADDR_BIT 3
`define INTC1_STACK_BIT 2
`define INTC1_OSC_BIT 1

`define TRAP_FIELD_HI 4
`define TRAP_FIELD_LO 1
`define TRAP_COUNT 4

`define PRIO_FIELD_RESET 3'h0
`define PRIO_FIELD_ALL_ONES 3'h7
`define TRAP_RESET 4'h0
`define MASK_RESET 4'h0

`endif

// ---- logic/cpu_priority_and_trap_status.v ----
// cpu priority level holder, nesting control and trap-status flags behind a wishbone slave
// assumes core-side strobes are synchronous to CORE_CLK_I and one cycle long
//
// Summary of operation
// [RULE1] the low three bits of the cpu priority level live in alu status bits 7 to 5, values 0 to 6 meaning levels 0 to 6.
// [RULE2] a field value of 7 means level 7 and blocks every user interrupt from being taken.
// [RULE3] the full level is the core control bit 3 placed above the three-bit field.
// [RULE4] with the msb set, field values 0 to 7 stand for levels 8 to 15.
// [RULE5] the msb reads one when the level is above 7 and zero when it is 7 or less.
// [RULE6] software may read and clear the msb but never set it.
// [RULE7] while nesting disable is one, software writes cannot change the three-bit field.
// [RULE8] nesting disable at one stops nesting; at zero a higher-priority request may preempt one in service.
// [RULE9] the arithmetic trap flag at bit 4 sets on an overflow trap.
// [RULE10] the address trap flag at bit 3 sets on an address error trap.
// [RULE11] the stack trap flag at bit 2 and oscillator trap flag at bit 1 set on their traps.
// [RULE12] unused bits of interrupt control register one ignore writes and read zero.
// [RULE13] reset clears the field, its msb, nesting disable and all trap flags.
// [RULE14] software raises or lowers the level by writing the three-bit field.
// [RULE15] software can never set the msb, so it can never mask traps by raising the level above 7.
// [RULE16] each trap flag stays set until software writes zero to it.
// [RULE17] a field write counts for acceptance decisions from the next cycle on.
//
// Our own choices: the placing of the registers and the Wishbone register port.
`include "cpu_priority_defines.vh"

module cpu_priority_and_trap_status #(
    parameter PRIO_W = 3
) (
    input wire CORE_CLK_I,
    input wire SRST_I,
    input wire CYC_I,
    input wire STB_I,
    input wire WE_I,
    input wire [3:0] ADR_I,
    input wire [3:0] SEL_I,
    input wire [31:0] DAT_I,
    output reg [31:0] DAT_O,
    output reg ACK_O,
    input wire CORE_PRIO_LOAD_I,
    input wire [PRIO_W:0] CORE_PRIO_I,
    input wire IN_SERVICE_I,
    input wire [PRIO_W:0] SERVICE_PRIO_I,
    input wire REQ_VALID_I,
    input wire [PRIO_W:0] REQ_PRIO_I,
    input wire ARITH_TRAP_I,
    input wire ADDR_TRAP_I,
    input wire STACK_TRAP_I,
    input wire OSC_TRAP_I,
    output wire [PRIO_W:0] CPU_LEVEL_O,
    output wire USER_IRQ_BLOCKED_O,
    output wire REQ_ACCEPT_O,
    output wire NESTING_DISABLE_O,
    output wire IRQ_O
);
    reg [PRIO_W-1:0] prio_field_reg;
    reg [PRIO_W-1:0] prio_field_next;
    reg prio_msb_reg;
    reg prio_msb_next;
    reg nest_dis_reg;
    reg nest_dis_next;
    reg [3:0] trap_mask_reg;
    reg [3:0] trap_mask_next;
    reg [31:0] rdata_next;
    wire [3:0] trap_flags;
    wire bus_req;
    wire bus_wr;
    wire lane0;
    wire lane1;
    wire wr_alu;
    wire wr_core;
    wire wr_intc1;
    wire wr_mask;
    wire [3:0] trap_events;
    wire [PRIO_W:0] level;

    function [31:0] intc1_word;
        input nd;
        input [3:0] fl;
        begin
            intc1_word = 32'h0000_0000; // see [RULE12]
            intc1_word[`INTC1_NEST_DIS_BIT] = nd;
            intc1_word[`TRAP_FIELD_HI:`TRAP_FIELD_LO] = fl;
        end
    endfunction

    assign bus_req = CYC_I & STB_I & ~ACK_O;
    assign bus_wr = bus_req & WE_I;
    assign lane0 = SEL_I[0];
    assign lane1 = SEL_I[1];
    assign wr_alu = bus_wr & lane0 & (ADR_I == `OFS_ALU_STATUS);
    assign wr_core = bus_wr & lane0 & (ADR_I == `OFS_CORE_CONTROL);
    assign wr_intc1 = bus_wr & (ADR_I == `OFS_INT_CONTROL_ONE);
    assign wr_mask = bus_wr & lane0 & (ADR_I == `OFS_TRAP_MASK);

    assign trap_events = {ARITH_TRAP_I, ADDR_TRAP_I, STACK_TRAP_I, OSC_TRAP_I};

    trap_flags #(
        .N(`TRAP_COUNT)
    ) u_trap_flags (
        .clk_i(CORE_CLK_I),
        .rst_i(SRST_I),
        .event_i(trap_events),
        .write_i(wr_intc1 & lane0),
        .wdata_i(DAT_I[`TRAP_FIELD_HI:`TRAP_FIELD_LO]),
        .mask_i(trap_mask_reg),
        .flags_o(trap_flags),
        .irq_o(IRQ_O)
    );

    // priority state: core loads take precedence over a same-cycle software write
    always @* begin
        prio_field_next = prio_field_reg;
        prio_msb_next = prio_msb_reg;
        nest_dis_next = nest_dis_reg;
        trap_mask_next = trap_mask_reg;
        if (wr_alu && !nest_dis_reg) begin
            prio_field_next = DAT_I[`ALU_PRIO_HI:`ALU_PRIO_LO]; // see [RULE7] see [RULE14]
        end
        if (wr_core && !DAT_I[`CORE_PRIO_MSB_BIT]) begin
            prio_msb_next = 1'b0; // see [RULE6] see [RULE15]
        end
        if (wr_intc1 && lane1) begin
            nest_dis_next = DAT_I[`INTC1_NEST_DIS_BIT];
        end
        if (wr_mask) begin
            trap_mask_next = DAT_I[3:0];
        end
        // the core alone may raise the msb, e.g. on trap entry
        if (CORE_PRIO_LOAD_I) begin
            prio_field_next = CORE_PRIO_I[PRIO_W-1:0];
            prio_msb_next = CORE_PRIO_I[PRIO_W];
        end
    end

    always @(posedge CORE_CLK_I) begin
        if (SRST_I) begin
            prio_field_reg <= `PRIO_FIELD_RESET; // see [RULE13]
            prio_msb_reg <= 1'b0;
            nest_dis_reg <= 1'b0;
            trap_mask_reg <= `MASK_RESET;
        end else begin
            prio_field_reg <= prio_field_next; // see [RULE17]
            prio_msb_reg <= prio_msb_next;
            nest_dis_reg <= nest_dis_next;
            trap_mask_reg <= trap_mask_next;
        end
    end

    assign level = {prio_msb_reg, prio_field_reg}; // see [RULE3] see [RULE4] see [RULE1]
    assign CPU_LEVEL_O = level;
    assign NESTING_DISABLE_O = nest_dis_reg;
    // field all ones blocks user sources even at the lower bank
    assign USER_IRQ_BLOCKED_O = prio_msb_reg | (prio_field_reg == `PRIO_FIELD_ALL_ONES); // see [RULE2]
    // request must outrank the cpu; with nesting off nothing is taken while in service
    assign REQ_ACCEPT_O = REQ_VALID_I & ~USER_IRQ_BLOCKED_O & (REQ_PRIO_I > level) &
                          ~(IN_SERVICE_I & (nest_dis_reg | (REQ_PRIO_I <= SERVICE_PRIO_I))); // see [RULE8]

    always @* begin
        rdata_next = 32'h0000_0000;
        case (ADR_I)
            `OFS_ALU_STATUS: begin
                rdata_next[`ALU_PRIO_HI:`ALU_PRIO_LO] = prio_field_reg;
            end
            `OFS_CORE_CONTROL: begin
                rdata_next[`CORE_PRIO_MSB_BIT] = prio_msb_reg; // see [RULE5]
            end
            `OFS_INT_CONTROL_ONE: begin
                rdata_next = intc1_word(nest_dis_reg, trap_flags);
            end
            `OFS_TRAP_MASK: begin
                rdata_next[3:0] = trap_mask_reg;
            end
            default: begin
                rdata_next = 32'h0000_0000;
            end
        endcase
    end

    // one wait-free answer per request; unmapped addresses ack with zero data
    always @(posedge CORE_CLK_I) begin
        if (SRST_I) begin
            ACK_O <= 1'b0;
            DAT_O <= 32'h0000_0000;
        end else begin
            ACK_O <= bus_req;
            if (bus_req && !WE_I) begin
                DAT_O <= rdata_next;
            end
        end
    end
endmodule

// ---- logic/trap_flags.v ----
// sticky trap-status flags with write-zero clear and interrupt mask gating
// assumes one clock and synchronous active-high reset from the parent
`include "cpu_priority_defines.vh"

module trap_flags #(
    parameter N = `TRAP_COUNT
) (
    input wire clk_i,
    input wire rst_i,
    input wire [N-1:0] event_i,
    input wire write_i,
    input wire [N-1:0] wdata_i,
    input wire [N-1:0] mask_i,
    output reg [N-1:0] flags_o,
    output wire irq_o
);
    reg [N-1:0] flags_next;

    // flag sets on its event and holds until software writes zero; set wins a same-cycle clear
    always @* begin
        flags_next = flags_o;
        if (write_i) begin
            flags_next = flags_o & wdata_i; // see [RULE16]
        end
        flags_next = flags_next | event_i; // see [RULE9] see [RULE10] see [RULE11]
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            flags_o <= {N{1'b0}}; // see [RULE13]
        end else begin
            flags_o <= flags_next;
        end
    end

    assign irq_o = |(flags_o & mask_i);
endmodule
